// ---- rtl/tdrb_pkg.sv ----
/*
 Package of the trim and dither register bank: offsets, field positions,
 reset values and bus widths.
 Assumes an APB slave with 32-bit data; register offsets are word indexes.
*/
// What this block does
// - Channel A gain trim, 8-bit, fuse-loaded, writable
// - Channel B gain trim, 8-bit, fuse-loaded, writable
// - Reference trim in 3:0, 7:4 reserved
// - Channel A termination trim, fuse-loaded, writable
// - Channel B termination trim, fuse-loaded, writable
// - Bit 0 enables dither, resets to 1, then fuse-loaded
// - Bit 1 selects large dither amplitude
// - Bit 2 places subtraction rounding error
// - Dither bits 7:3 reserved, read as zero
package tdrb_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;

   // Printed offsets are not all multiples of four: they are word indexes
   localparam logic [9:0] IDX_GAIN_A = 10'h07A;
   localparam logic [9:0] IDX_GAIN_B = 10'h07B;
   localparam logic [9:0] IDX_REF    = 10'h07C;
   localparam logic [9:0] IDX_TERM_A = 10'h07E;
   localparam logic [9:0] IDX_TERM_B = 10'h07F;
   localparam logic [9:0] IDX_DITHER = 10'h09D;

   // Field positions
   localparam int unsigned REF_MSB      = 3;
   localparam int unsigned DITH_EN_BIT  = 0;
   localparam int unsigned DITH_AMP_BIT = 1;
   localparam int unsigned DITH_ERR_BIT = 2;
   localparam int unsigned DITH_MSB     = 2;

   // Printed reset values, used while the fuse image is not yet loaded
   localparam logic [7:0] RST_TRIM   = 8'h00;
   localparam logic [7:0] RST_DITHER = 8'h01;
   localparam logic [7:0] REF_MASK   = 8'h0F;
   localparam logic [7:0] DITH_MASK  = 8'h07;
endpackage : tdrb_pkg

// ---- rtl/tdrb_wr_if.sv ----
/*
 Interface carrying decoded register writes from the APB decode to the
 register storage. Assumes a single clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface tdrb_wr_if;
   logic [5:0] sel;   // One-hot register select, order gain A..dither
   logic       we;    // Write strobe, one cycle
   logic [7:0] wdata; // Low byte of write data
   logic       load;  // Fuse load pulse, wins over a write
   logic [7:0] fuse [6];
   modport master (output sel, output we, output wdata, output load, output fuse);
   modport slave  (input sel, input we, input wdata, input load, input fuse);
endinterface : tdrb_wr_if
`default_nettype wire

// ---- rtl/tdrb_store.sv ----
/*
 Register storage for the six trim and dither registers.
 Assumes writes and fuse loads arrive over tdrb_wr_if on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module tdrb_store (
   input  wire logic        pclk,
   input  wire logic        presetn,
   tdrb_wr_if.slave         wr,
   output logic [7:0]       q [6]
);
   // Reserved bits are kept at zero so reads show them as zero
   function automatic logic [7:0] field_mask(input int unsigned i);
      if (i == 2)
         return tdrb_pkg::REF_MASK;
      else if (i == 5)
         return tdrb_pkg::DITH_MASK;
      else
         return 8'hFF;
   endfunction

   // Fuse load wins; otherwise a written value holds until the next write or reset
   for (genvar g = 0; g < 6; g++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            q[g] <= (g == 5) ? tdrb_pkg::RST_DITHER : tdrb_pkg::RST_TRIM;
         end else if (wr.load) begin
            q[g] <= wr.fuse[g] & field_mask(g);
         end else if (wr.we && wr.sel[g]) begin
            q[g] <= wr.wdata & field_mask(g);
         end
      end
   end
endmodule : tdrb_store
`default_nettype wire

// ---- rtl/tdrb_top.sv ----
/*
 Trim and dither register bank: APB slave, fuse load after reset, and the
 trim and dither outputs to the analog side.
 Assumes fuse_* inputs are stable from reset release onward, synchronous to pclk.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tdrb_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  fuse_gain_chan_a,
   input  wire logic [7:0]  fuse_gain_chan_b,
   input  wire logic [7:0]  fuse_reference,
   input  wire logic [7:0]  fuse_term_chan_a,
   input  wire logic [7:0]  fuse_term_chan_b,
   input  wire logic [7:0]  fuse_dither,
   output logic      [7:0]  gain_trim_chan_a,
   output logic      [7:0]  gain_trim_chan_b,
   output logic      [3:0]  reference_adjust,
   output logic      [7:0]  termination_adjust_chan_a,
   output logic      [7:0]  termination_adjust_chan_b,
   output logic             dither_enable,
   output logic             dither_amplitude_select,
   output logic             rounding_error_placement,
   output logic             fuse_loaded
);
   tdrb_wr_if wr ();
   logic [7:0] q [6];
   logic       load_done_reg;
   logic [31:0] prdata_reg;
   logic       slverr_reg;

   // Address decode: word index, misaligned or unmapped is an error
   wire        aligned = (paddr[1:0] == 2'b00);
   wire [9:0]  idx     = paddr[11:2];
   wire [5:0]  hit;
   assign hit[0] = aligned && idx == tdrb_pkg::IDX_GAIN_A;
   assign hit[1] = aligned && idx == tdrb_pkg::IDX_GAIN_B;
   assign hit[2] = aligned && idx == tdrb_pkg::IDX_REF;
   assign hit[3] = aligned && idx == tdrb_pkg::IDX_TERM_A;
   assign hit[4] = aligned && idx == tdrb_pkg::IDX_TERM_B;
   assign hit[5] = aligned && idx == tdrb_pkg::IDX_DITHER;
   wire        mapped = |hit;
   wire        access = psel && penable;
   // Only the low byte lane carries register data; other lanes are ignored
   wire        wr_ok  = access && pwrite && mapped && pstrb[0];

   // Write path and one fuse load in the first cycle after reset release
   assign wr.sel   = hit;
   assign wr.we    = wr_ok && load_done_reg;
   assign wr.wdata = pwdata[7:0];
   assign wr.load  = !load_done_reg;
   assign wr.fuse[0] = fuse_gain_chan_a;
   assign wr.fuse[1] = fuse_gain_chan_b;
   assign wr.fuse[2] = fuse_reference;
   assign wr.fuse[3] = fuse_term_chan_a;
   assign wr.fuse[4] = fuse_term_chan_b;
   assign wr.fuse[5] = fuse_dither;

   tdrb_store u_store (
      .pclk    (pclk),
      .presetn (presetn),
      .wr      (wr.slave),
      .q       (q)
   );

   // Load flag: strap-style capture after release, never from a port under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         load_done_reg <= 1'b0;
      else
         load_done_reg <= 1'b1;
   end

   // Read mux, registered at the setup phase so prdata comes from flip-flops
   wire [7:0] rd_byte = ({8{hit[0]}} & q[0]) | ({8{hit[1]}} & q[1]) |
                        ({8{hit[2]}} & q[2]) | ({8{hit[3]}} & q[3]) |
                        ({8{hit[4]}} & q[4]) | ({8{hit[5]}} & q[5]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else if (psel && !penable) begin
         prdata_reg <= {24'h00_0000, rd_byte};
         slverr_reg <= !mapped;
      end
   end

   // Zero wait states after the fuse load; the load cycle stretches access
   assign pready  = load_done_reg;
   assign prdata  = prdata_reg;
   assign pslverr = access && slverr_reg;

   // Analog control outputs
   assign gain_trim_chan_a          = q[0];
   assign gain_trim_chan_b          = q[1];
   assign reference_adjust          = q[2][tdrb_pkg::REF_MSB:0];
   assign termination_adjust_chan_a = q[3];
   assign termination_adjust_chan_b = q[4];
   assign dither_enable             = q[5][tdrb_pkg::DITH_EN_BIT];
   assign dither_amplitude_select   = q[5][tdrb_pkg::DITH_AMP_BIT];
   assign rounding_error_placement  = q[5][tdrb_pkg::DITH_ERR_BIT];
   assign fuse_loaded               = load_done_reg;

   // Writes land at the access edge and show on the output next cycle
   a_gain_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[0] |=> gain_trim_chan_a == $past(pwdata[7:0]))
      else $error("gain A write not applied");
   a_gainb_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[1] |=> gain_trim_chan_b == $past(pwdata[7:0]))
      else $error("gain B write not applied");
   a_ref_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      q[2][7:4] == 4'h0)
      else $error("reference reserved bits nonzero");
   a_terma_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[3] |=> termination_adjust_chan_a == $past(pwdata[7:0]))
      else $error("termination A write not applied");
   a_termb_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[4] |=> termination_adjust_chan_b == $past(pwdata[7:0]))
      else $error("termination B write not applied");
   a_dither_load: assert property (@(posedge pclk) disable iff (!presetn)
      !load_done_reg |=> dither_enable == $past(fuse_dither[0])
                         && dither_amplitude_select == $past(fuse_dither[1]))
      else $error("dither fuse load wrong");
   a_dither_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[5] |=> dither_enable == $past(pwdata[0])
                                          && dither_amplitude_select == $past(pwdata[1]))
      else $error("dither write not applied");
   a_err_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && load_done_reg && hit[5] |=> rounding_error_placement == $past(pwdata[2]))
      else $error("rounding bit write not applied");
   a_dith_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      q[5][7:3] == 5'h00)
      else $error("dither reserved bits nonzero");
   a_value_holds: assert property (@(posedge pclk) disable iff (!presetn)
      load_done_reg && !(wr_ok && hit[0]) |=> $stable(gain_trim_chan_a))
      else $error("gain A changed without write");
endmodule : tdrb_top
`default_nettype wire

// ---- sim/tdrb_bench.sv ----
/*
 Self-checking bench of the trim and dither register bank: APB accesses,
 fuse load after reset, refused accesses and a reset in mid-run.
 Assumes tdrb_top and tdrb_pkg are compiled first; pclk runs at 125 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
module trim_and_dither_register_bank_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  outs [6];
   logic [3:0]  ref_q;
   logic [2:0]  dith_q;
   logic [31:0] rd_q;
   logic        err_q;
   int          bad_count = 0;
   int          n_compared = 0;
   // Fuse image has reserved bits set on purpose, so masking shows up
   logic [7:0]  fz [6] = '{8'h11, 8'h22, 8'hA7, 8'h33, 8'h44, 8'hF8};
   logic [7:0]  fz_exp [6] = '{8'h11, 8'h22, 8'h07, 8'h33, 8'h44, 8'h00};
   // Rows: byte address, write data, output slot, expected readback
   logic [11:0] row_a [8] = '{12'h1E8, 12'h1EC, 12'h1F0, 12'h1F8, 12'h1FC, 12'h274, 12'h274, 12'h274};
   logic [31:0] row_d [8] = '{32'hFFFFFF5A, 32'hA5, 32'hFF, 32'h3C, 32'hC3, 32'hFF, 32'h02, 32'h04};
   int          row_id [8] = '{0, 1, 2, 3, 4, 5, 5, 5};
   logic [7:0]  row_x [8] = '{8'h5A, 8'hA5, 8'h0F, 8'h3C, 8'hC3, 8'h07, 8'h02, 8'h04};

   // Clock, 8 ns period
   always #4 pclk = ~pclk;

   tdrb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_gain_chan_a(fz[0]), .fuse_gain_chan_b(fz[1]), .fuse_reference(fz[2]),
      .fuse_term_chan_a(fz[3]), .fuse_term_chan_b(fz[4]), .fuse_dither(fz[5]),
      .gain_trim_chan_a(outs[0]), .gain_trim_chan_b(outs[1]), .reference_adjust(ref_q),
      .termination_adjust_chan_a(outs[3]), .termination_adjust_chan_b(outs[4]),
      .dither_enable(dith_q[0]), .dither_amplitude_select(dith_q[1]),
      .rounding_error_placement(dith_q[2]), .fuse_loaded());
   // Narrow outputs widened into byte slots for table compares
   assign outs[2] = {4'h0, ref_q};
   assign outs[5] = {5'h00, dith_q};

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, left in access phase so a back-to-back setup may follow
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
   endtask

   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      @(posedge pclk);
   endtask

   task automatic print_verdict();
      if (bad_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog: the whole run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 6; i++) chk(outs[i], (i == 5) ? 8'h01 : 8'h00);
      presetn <= 1'b1;
      idle();
      for (int i = 0; i < 6; i++) chk(outs[i], fz_exp[i]);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, row_a[i], row_d[i], 4'hF);
         idle();
         chk(outs[row_id[i]], row_x[i]);
         apb(1'b0, row_a[i], 32'h00000000, 4'hF);
         idle();
         chk(rd_q, {24'h000000, row_x[i]});
         chk(err_q, 1'b0);
      end
      // Refused writes leave the stored value alone; an unmapped read errors
      apb(1'b1, 12'h1E8, 32'h00, 4'hE);
      idle();
      chk(outs[0], 8'h5A);
      apb(1'b1, 12'h1E9, 32'h00, 4'hF);
      idle();
      chk(err_q, 1'b1);
      chk(outs[0], 8'h5A);
      apb(1'b0, 12'h1F4, 32'h00, 4'hF);
      idle();
      chk({err_q, rd_q}, {1'b1, 32'h00000000});
      // Back-to-back write then read of the same register
      apb(1'b1, 12'h1EC, 32'h77, 4'hF);
      apb(1'b0, 12'h1EC, 32'h00, 4'hF);
      idle();
      chk(rd_q, 32'h00000077);
      // Reset in mid-run brings the fuse image back
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      idle();
      for (int i = 0; i < 6; i++) chk(outs[i], fz_exp[i]);
      print_verdict();
   end
endmodule // trim_and_dither_register_bank_bench
`default_nettype wire
